// [dv/llc_host.sv]
// Host controller model that reads and writes the block's subaddress port.
`timescale 1ns/1ns

module llc_host (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata_r,
  input  wire logic       reg_rvalid_r
);
  // Idle port at time zero; first request waits for the bench to release reset.
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe; afterwards the buses show the inverse so stale data never matches.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read strobe; the answer is taken at the edge that follows it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    v = reg_rvalid_r;
    d = reg_rdata_r;
  endtask : rd
endmodule : llc_host

// [dv/llc_level_loop_sva.sv]
// Concurrent checks on the level loop block's register port and control outputs.
`timescale 1ns/1ns

module llc_level_loop_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic       reg_rvalid_r,
  input wire logic       level_window,
  input wire logic [2:0] coarse_clamp_en,
  input wire logic       bottom_clamp_sel,
  input wire logic [2:0] fine_clamp_on_r,
  input wire logic       common_mode_shift_on_r,
  input wire logic [1:0] clamp_time_constant_r,
  input wire logic       sog_pd_r,
  input wire logic       slicer_pd_r,
  input wire logic       reference_pd_r,
  input wire logic       current_pd_r,
  input wire logic [2:0] converter_pd_r
);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  read_answer_a: assert property (
    reg_rd |=> reg_rvalid_r) else $error("read strobe got no valid answer");
  enable_mask_a: assert property (
    reg_rd && reg_addr == 8'h26 |=> reg_rdata_r[6:0] == 7'h00)
    else $error("enable register shows bits below bit 7");
  high_rsvd_a: assert property (
    reg_rd && reg_addr == 8'h27 |=> reg_rdata_r[7:6] == 2'h0)
    else $error("upper bits register shows reserved bits");
  coarse_override_a: assert property (
    coarse_clamp_en != 3'h0 |=> (fine_clamp_on_r & $past(coarse_clamp_en)) == 3'h0)
    else $error("fine clamp on while coarse clamp enabled");
  cm_shift_gate_a: assert property (
    common_mode_shift_on_r |-> $past(bottom_clamp_sel) && $past(coarse_clamp_en) == 3'h0)
    else $error("common mode shift on outside fine bottom clamping");
  time_const_a: assert property (
    reg_wr && reg_addr == 8'h2a |=> ##1 clamp_time_constant_r == $past(reg_wdata[4:3], 2))
    else $error("clamp time constant does not follow write");
  power_bits_a: assert property (
    reg_wr && reg_addr == 8'h2b |=> ##1
    {sog_pd_r, slicer_pd_r, reference_pd_r, current_pd_r} == $past(reg_wdata[6:3], 2))
    else $error("power down outputs do not follow write");
  conv_pd_a: assert property (
    reg_wr && reg_addr == 8'h2b |=> ##1 converter_pd_r == $past(reg_wdata[2:0], 2))
    else $error("converter power down does not follow write");

  // Main scenarios reached.
  cover property (reg_wr && reg_addr == 8'h2b);
  cover property (coarse_clamp_en != 3'h0 && bottom_clamp_sel);
  cover property ($fell(level_window));
endmodule : llc_level_loop_sva

bind llc_level_loop llc_level_loop_sva #(.ADDR_W(ADDR_W)) llc_level_loop_sva_i (
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .reg_rvalid_r(reg_rvalid_r), .level_window(level_window),
  .coarse_clamp_en(coarse_clamp_en), .bottom_clamp_sel(bottom_clamp_sel),
  .fine_clamp_on_r(fine_clamp_on_r), .common_mode_shift_on_r(common_mode_shift_on_r),
  .clamp_time_constant_r(clamp_time_constant_r), .sog_pd_r(sog_pd_r),
  .slicer_pd_r(slicer_pd_r), .reference_pd_r(reference_pd_r),
  .current_pd_r(current_pd_r), .converter_pd_r(converter_pd_r));

// [dv/llc_level_loop_tb.sv]
// Self-checking bench for the level loop, clamp and power control block.
`timescale 1ns/1ns

module llc_level_loop_tb;
  logic       clk_sys = 1'b0;
  logic       srst    = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, d;
  logic       reg_wr, reg_rd, reg_rvalid_r, v, cm_on, sog, slc, refp, curp;
  logic [9:0] adc_red = 10'h200, adc_green = 10'h200, adc_blue = 10'h200;
  logic       level_window = 1'b0;
  logic       bottom_clamp_sel = 1'b0;
  logic [2:0] coarse_clamp_en = 3'h0;
  logic [2:0] fine_on, conv_pd;
  logic [1:0] tconst;
  logic [7:0] ra [9] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h30};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h53, 8'h08, 8'h07, 8'h00, 8'h00};
  logic [7:0] pv [2] = '{8'hd5, 8'h2a};
  int         miscompares = 0;
  int         n_tests = 0;

  always #2 clk_sys = ~clk_sys;

  llc_level_loop #(.ADDR_W(8)) llc_level_loop_i (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .adc_red(adc_red), .adc_green(adc_green), .adc_blue(adc_blue),
    .level_window(level_window), .coarse_clamp_en(coarse_clamp_en),
    .bottom_clamp_sel(bottom_clamp_sel), .fine_clamp_on_r(fine_on),
    .common_mode_shift_on_r(cm_on), .clamp_time_constant_r(tconst), .sog_pd_r(sog),
    .slicer_pd_r(slc), .reference_pd_r(refp), .current_pd_r(curp), .converter_pd_r(conv_pd));

  llc_host llc_host_i (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r));

  // ---------------------------------------------------------------------------
  // Check, read and line tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    llc_host_i.rd(a, d, v);
    chk(10'(v), 10'h001);
    chk(10'(d), 10'(exp));
  endtask : rdc

  // One line: the window stays high for exactly two sampled edges.
  task automatic line(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b);
    @(posedge clk_sys);
    adc_red      <= r;
    adc_green    <= g;
    adc_blue     <= b;
    level_window <= 1'b1;
    repeat (2) @(posedge clk_sys);
    level_window <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : line

  task automatic close_out;
    $display("Counts: %0d checks, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(10'(fine_on), 10'h007);
    chk(10'({cm_on, tconst, sog, slc, refp, curp, conv_pd}), 10'h000);
    for (int i = 0; i < 9; i++) rdc(ra[i], rv[i]);
    $display("Test reset_values done");
    foreach (pv[i]) begin
      llc_host_i.wr(8'h2b, pv[i]);
      repeat (2) @(posedge clk_sys);
      chk(10'({sog, slc}), 10'(pv[i][6:5]));
      chk(10'({refp, curp}), 10'(pv[i][4:3]));
      chk(10'(conv_pd), 10'(pv[i][2:0]));
      rdc(8'h2b, pv[i] & 8'h7f);
    end
    llc_host_i.wr(8'h28, 8'hff);
    rdc(8'h28, 8'h7f);
    llc_host_i.wr(8'h29, 8'h08);
    $display("Test power_and_access done");
    bottom_clamp_sel <= 1'b1;
    llc_host_i.wr(8'h2a, 8'h9d);
    repeat (2) @(posedge clk_sys);
    chk(10'(fine_on), 10'h001);
    chk(10'({cm_on, tconst}), 10'h007);
    coarse_clamp_en <= 3'b001;
    repeat (2) @(posedge clk_sys);
    chk(10'({cm_on, fine_on}), 10'h000);
    llc_host_i.wr(8'h2a, 8'h07);
    coarse_clamp_en <= 3'b100;
    repeat (2) @(posedge clk_sys);
    chk(10'(fine_on), 10'h003);
    coarse_clamp_en <= 3'b000;
    $display("Test fine_clamp done");
    llc_host_i.wr(8'h28, 8'h00);
    line(10'h300, 10'h020, 10'h1ff);
    rdc(8'h24, 8'h20);
    rdc(8'h25, 8'h00);
    rdc(8'h27, 8'h1b);
    llc_host_i.wr(8'h24, 8'h55);
    rdc(8'h24, 8'h20);
    llc_host_i.wr(8'h28, 8'h01);
    line(10'h300, 10'h300, 10'h1ff);
    rdc(8'h24, 8'h80);
    rdc(8'h25, 8'h80);
    rdc(8'h27, 8'h03);
    llc_host_i.wr(8'h28, 8'h08);
    line(10'h000, 10'h300, 10'h1ff);
    rdc(8'h24, 8'hc0);
    rdc(8'h25, 8'h40);
    rdc(8'h27, 8'h33);
    llc_host_i.wr(8'h26, 8'h7f);
    rdc(8'h26, 8'h00);
    line(10'h000, 10'h000, 10'h000);
    rdc(8'h24, 8'hc0);
    llc_host_i.wr(8'h26, 8'h80);
    rdc(8'h26, 8'h80);
    // A window longer than the span must drop its oldest sample from the sum.
    llc_host_i.wr(8'h28, 8'h00);
    @(posedge clk_sys);
    adc_green    <= 10'h000;
    level_window <= 1'b1;
    @(posedge clk_sys);
    adc_green    <= 10'h300;
    repeat (2) @(posedge clk_sys);
    level_window <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rdc(8'h24, 8'h00);
    rdc(8'h27, 8'h26);
    $display("Test level_loop done");
    close_out();
  end
endmodule : llc_level_loop_tb

// [hdl/llc_level_loop.sv]
// Level loop filter, fine clamp control and power-down register block.
`timescale 1ns/1ns

module llc_level_loop #(
  parameter int ADDR_W = 8
) (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata_r,
  output logic                             reg_rvalid_r,
  input  wire logic [llc_pkg::DATA_W-1:0]  adc_red,
  input  wire logic [llc_pkg::DATA_W-1:0]  adc_green,
  input  wire logic [llc_pkg::DATA_W-1:0]  adc_blue,
  input  wire logic                        level_window,
  input  wire logic [llc_pkg::NUM_CH-1:0]  coarse_clamp_en,
  input  wire logic                        bottom_clamp_sel,
  output logic [llc_pkg::NUM_CH-1:0]       fine_clamp_on_r,
  output logic                             common_mode_shift_on_r,
  output logic [1:0]                       clamp_time_constant_r,
  output logic                             sog_pd_r,
  output logic                             slicer_pd_r,
  output logic                             reference_pd_r,
  output logic                             current_pd_r,
  output logic [llc_pkg::NUM_CH-1:0]       converter_pd_r
);

  localparam int DW    = llc_pkg::DATA_W;
  localparam int NCH   = llc_pkg::NUM_CH;
  localparam int SUM_W = DW + ADDR_W + 1;
  localparam int ACC_W = DW + llc_pkg::FRAC_W;

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The widest horizontal code asks for 256 samples of history.
  if (ADDR_W < 8 || ADDR_W > 12) begin : g_bad_addr
    $error("llc_level_loop: ADDR_W must be between 8 and 12");
  end

  // Offset-binary converter code to two's-complement level.
  function automatic logic [DW-1:0] to_level(input logic [DW-1:0] code);
    to_level = code - llc_pkg::MID_CODE;
  endfunction : to_level

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [7:0] enable_r, enable_nxt;
  logic [7:0] filter_r, filter_nxt;
  logic [7:0] fixed_r, fixed_nxt;
  logic [7:0] fine_r, fine_nxt;
  logic [7:0] power_r, power_nxt;
  logic [7:0] rdata_nxt;
  logic [ACC_W-1:0] acc_r [NCH];
  logic [DW*NCH-1:0] level_all;
  logic [DW-1:0] res [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_res
    assign res[c] = acc_r[c][ACC_W-1:llc_pkg::FRAC_W];
  end

  // Writes land on the named byte; result addresses are not writable.
  always_comb begin
    enable_nxt = enable_r;
    filter_nxt = filter_r;
    fixed_nxt  = fixed_r;
    fine_nxt   = fine_r;
    power_nxt  = power_r;
    if (reg_wr) begin
      unique case (reg_addr)
        llc_pkg::ADDR_ENABLE: enable_nxt = reg_wdata & llc_pkg::MASK_ENABLE;
        llc_pkg::ADDR_FILTER: filter_nxt = reg_wdata & llc_pkg::MASK_FILTER;
        llc_pkg::ADDR_FIXED:  fixed_nxt  = reg_wdata;
        llc_pkg::ADDR_FINE:   fine_nxt   = reg_wdata;
        llc_pkg::ADDR_POWER:  power_nxt  = reg_wdata & llc_pkg::MASK_POWER;
        default: ; // Results and unmapped bytes ignore writes.
      endcase
    end
  end

  // Read data are captured one cycle after the strobe; reading changes nothing.
  always_comb begin
    rdata_nxt = reg_rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        llc_pkg::ADDR_GREEN_LOW: rdata_nxt = res[llc_pkg::CH_GREEN][7:0];
        llc_pkg::ADDR_RED_LOW:   rdata_nxt = res[llc_pkg::CH_RED][7:0];
        llc_pkg::ADDR_ENABLE:    rdata_nxt = enable_r;
        llc_pkg::ADDR_HIGH: begin
          rdata_nxt = '0;
          rdata_nxt[llc_pkg::HI_RED_LSB+:2]   = res[llc_pkg::CH_RED][9:8];
          rdata_nxt[llc_pkg::HI_GREEN_LSB+:2] = res[llc_pkg::CH_GREEN][9:8];
          rdata_nxt[llc_pkg::HI_BLUE_LSB+:2]  = res[llc_pkg::CH_BLUE][9:8];
        end
        llc_pkg::ADDR_FILTER: rdata_nxt = filter_r;
        llc_pkg::ADDR_FIXED:  rdata_nxt = fixed_r;
        llc_pkg::ADDR_FINE:   rdata_nxt = fine_r;
        llc_pkg::ADDR_POWER:  rdata_nxt = power_r;
        default:              rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_r     <= llc_pkg::RST_ENABLE;
      filter_r     <= llc_pkg::RST_FILTER;
      fixed_r      <= llc_pkg::RST_FIXED;
      fine_r       <= llc_pkg::RST_FINE;
      power_r      <= llc_pkg::RST_POWER;
      reg_rdata_r  <= '0;
      reg_rvalid_r <= 1'b0;
    end else begin
      enable_r     <= enable_nxt;
      filter_r     <= filter_nxt;
      fixed_r      <= fixed_nxt;
      fine_r       <= fine_nxt;
      power_r      <= power_nxt;
      reg_rdata_r  <= rdata_nxt;
      reg_rvalid_r <= reg_rd;
    end
  end

  // ---------------------------------------------------------------------------
  // Clamp and power outputs
  // ---------------------------------------------------------------------------
  logic [NCH-1:0] fine_on_nxt;
  logic           cm_on_nxt;

  // Coarse clamping wins over the fine enables channel by channel; the common-mode
  // shift only means something with fine bottom-level clamping on every channel.
  always_comb begin
    fine_on_nxt[llc_pkg::CH_RED]   = fine_r[llc_pkg::BIT_R];
    fine_on_nxt[llc_pkg::CH_GREEN] = fine_r[llc_pkg::BIT_GB];
    fine_on_nxt[llc_pkg::CH_BLUE]  = fine_r[llc_pkg::BIT_GB];
    fine_on_nxt = fine_on_nxt & ~coarse_clamp_en;
    cm_on_nxt   = fine_r[llc_pkg::BIT_CM] & bottom_clamp_sel & ~|coarse_clamp_en;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fine_clamp_on_r        <= '0;
      common_mode_shift_on_r <= 1'b0;
      clamp_time_constant_r  <= '0;
      sog_pd_r               <= 1'b0;
      slicer_pd_r            <= 1'b0;
      reference_pd_r         <= 1'b0;
      current_pd_r           <= 1'b0;
      converter_pd_r         <= '0;
    end else begin
      fine_clamp_on_r        <= fine_on_nxt;
      common_mode_shift_on_r <= cm_on_nxt;
      clamp_time_constant_r  <= fine_r[llc_pkg::TC_LSB+:2];
      sog_pd_r               <= power_r[llc_pkg::BIT_SOG_PD];
      slicer_pd_r            <= power_r[llc_pkg::BIT_SLICER_PD];
      reference_pd_r         <= power_r[llc_pkg::BIT_REF_PD];
      current_pd_r           <= power_r[llc_pkg::BIT_CUR_PD];
      converter_pd_r[llc_pkg::CH_BLUE]  <= power_r[llc_pkg::BIT_BLUE_PD];
      converter_pd_r[llc_pkg::CH_GREEN] <= power_r[llc_pkg::BIT_GREEN_PD];
      converter_pd_r[llc_pkg::CH_RED]   <= power_r[llc_pkg::BIT_RED_PD];
    end
  end

  // ---------------------------------------------------------------------------
  // Horizontal running average: sample history and pointers
  // ---------------------------------------------------------------------------
  logic              loop_en;
  logic              take;
  logic [3:0]        tap_log;
  logic [ADDR_W:0]   taps;
  logic [ADDR_W-1:0] wptr_r, wptr_nxt;
  logic [ADDR_W:0]   fill_r, fill_nxt;
  logic              win_d_r, first_r, first_nxt, sub_old_r, sub_old_nxt;
  logic              vld_r, vld_d_r;
  logic [DW*NCH-1:0] samp_r, old_data;

  assign loop_en   = enable_r[llc_pkg::BIT_LOOP_EN];
  assign take      = level_window & loop_en;
  assign tap_log   = {1'b0, filter_r[llc_pkg::HCODE_LSB+:3]} + 4'h1;
  assign taps      = (ADDR_W+1)'(1) << tap_log;
  assign level_all = {to_level(adc_blue), to_level(adc_green), to_level(adc_red)};

  // The fill count stops old slots from the previous line entering the sum.
  always_comb begin
    wptr_nxt    = wptr_r;
    fill_nxt    = fill_r;
    first_nxt   = 1'b0;
    sub_old_nxt = 1'b0;
    if (take) begin
      wptr_nxt    = wptr_r + 1'b1;
      first_nxt   = ~win_d_r;
      sub_old_nxt = win_d_r && (fill_r >= taps);
      if (!win_d_r) begin
        fill_nxt = (ADDR_W+1)'(1);
      end else if (fill_r < taps) begin
        fill_nxt = fill_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr_r    <= '0;
      fill_r    <= '0;
      win_d_r   <= 1'b0;
      first_r   <= 1'b0;
      sub_old_r <= 1'b0;
      vld_r     <= 1'b0;
      vld_d_r   <= 1'b0;
      samp_r    <= '0;
    end else begin
      wptr_r    <= wptr_nxt;
      fill_r    <= fill_nxt;
      win_d_r   <= take;
      first_r   <= first_nxt;
      sub_old_r <= sub_old_nxt;
      vld_r     <= take;
      vld_d_r   <= vld_r;
      samp_r    <= level_all;
    end
  end

  llc_sample_store #(
    .WIDTH  (DW*NCH),
    .ADDR_W (ADDR_W)
  ) u_store (
    .clk_sys (clk_sys),
    .srst    (srst),
    .we      (take),
    .waddr   (wptr_r),
    .wdata   (level_all),
    .raddr   (wptr_r - taps[ADDR_W-1:0]),
    .rdata_r (old_data)
  );

  // ---------------------------------------------------------------------------
  // Per-channel sums and per-line recursive filter
  // ---------------------------------------------------------------------------
  logic       line_end;
  logic [3:0] vshift;

  // The line ends once the last window sample has entered the sum.
  assign line_end = vld_d_r & ~vld_r;
  assign vshift   = (filter_r[llc_pkg::VCODE_LSB+:4] > llc_pkg::VCODE_MAX) ?
                    llc_pkg::VCODE_MAX : filter_r[llc_pkg::VCODE_LSB+:4];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [SUM_W-1:0] sum_r, sum_nxt, avg_full;
    logic signed [ACC_W:0]   delta;
    logic        [ACC_W-1:0] acc_nxt;

    // Running sum adds the new sample and drops the one that left the span;
    // the accumulator keeps ten fraction bits so tiny weights still move it.
    always_comb begin
      sum_nxt  = sum_r;
      acc_nxt  = acc_r[c];
      avg_full = sum_r >>> tap_log;
      delta    = $signed({avg_full[DW-1], avg_full[DW-1:0], {llc_pkg::FRAC_W{1'b0}}})
               - $signed({acc_r[c][ACC_W-1], acc_r[c]});
      if (vld_r) begin
        sum_nxt = (first_r ? SUM_W'(0) : sum_r)
                + SUM_W'($signed(samp_r[c*DW+:DW]))
                - (sub_old_r ? SUM_W'($signed(old_data[c*DW+:DW])) : SUM_W'(0));
      end
      if (line_end) begin
        acc_nxt = acc_r[c] + ACC_W'(delta >>> vshift);
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        sum_r    <= '0;
        acc_r[c] <= '0;
      end else begin
        sum_r    <= sum_nxt;
        acc_r[c] <= acc_nxt;
      end
    end
  end

endmodule : llc_level_loop

// [hdl/llc_pkg.sv]
// Constants shared by the level loop, clamp and power control block.
package llc_pkg;

  // ---------------------------------------------------------------------------
  // Register subaddresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_GREEN_LOW = 8'h24;
  localparam logic [7:0] ADDR_RED_LOW   = 8'h25;
  localparam logic [7:0] ADDR_ENABLE    = 8'h26;
  localparam logic [7:0] ADDR_HIGH      = 8'h27;
  localparam logic [7:0] ADDR_FILTER    = 8'h28;
  localparam logic [7:0] ADDR_FIXED     = 8'h29;
  localparam logic [7:0] ADDR_FINE      = 8'h2a;
  localparam logic [7:0] ADDR_POWER     = 8'h2b;

  // ---------------------------------------------------------------------------
  // Reset values and writable-bit masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE  = 8'h80;
  localparam logic [7:0] RST_FILTER  = 8'h53;
  localparam logic [7:0] RST_FIXED   = 8'h08;
  localparam logic [7:0] RST_FINE    = 8'h07;
  localparam logic [7:0] RST_POWER   = 8'h00;
  localparam logic [7:0] MASK_ENABLE = 8'h80;
  localparam logic [7:0] MASK_FILTER = 8'h7f;
  localparam logic [7:0] MASK_POWER  = 8'h7f;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_LOOP_EN   = 7;
  localparam int VCODE_LSB     = 3;
  localparam int HCODE_LSB     = 0;
  localparam int BIT_CM        = 7;
  localparam int TC_LSB        = 3;
  localparam int BIT_GB        = 1;
  localparam int BIT_R         = 0;
  localparam int BIT_SOG_PD    = 6;
  localparam int BIT_SLICER_PD = 5;
  localparam int BIT_REF_PD    = 4;
  localparam int BIT_CUR_PD    = 3;
  localparam int BIT_BLUE_PD   = 2;
  localparam int BIT_GREEN_PD  = 1;
  localparam int BIT_RED_PD    = 0;
  localparam int HI_RED_LSB    = 4;
  localparam int HI_GREEN_LSB  = 2;
  localparam int HI_BLUE_LSB   = 0;

  // ---------------------------------------------------------------------------
  // Channels and arithmetic
  // ---------------------------------------------------------------------------
  localparam int CH_RED   = 0;
  localparam int CH_GREEN = 1;
  localparam int CH_BLUE  = 2;
  localparam int NUM_CH   = 3;
  localparam int DATA_W   = 10;
  localparam int FRAC_W   = 10;
  localparam logic [3:0] VCODE_MAX = 4'ha;
  localparam logic [DATA_W-1:0] MID_CODE = 10'h200;

endpackage : llc_pkg

// [hdl/llc_sample_store.sv]
// Sample history memory for the running-average filter.
`timescale 1ns/1ns

module llc_sample_store #(
  parameter int WIDTH  = 30,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata_r
);

  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Read before write, so a read of the slot being overwritten returns the old word.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[raddr];
    end
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

endmodule : llc_sample_store
